// ### logic/attrib_pkg.sv
// Purpose: shared constants for the type B attribute command checker
// Assumes: byte-level frames decoded upstream on the same clock
// Notes:   register offsets are byte addresses of aligned 32-bit words
package attrib_pkg;
  // frame layout
  localparam logic [7:0]  CMD_ATTRIB     = 8'h1D;
  localparam logic [3:0]  FRAME_LEN      = 4'hB;   // cmd, 4 id, 4 params, 2 crc
  localparam logic [3:0]  IDX_CMD        = 4'h0;
  localparam logic [3:0]  IDX_ID0        = 4'h1;
  localparam logic [3:0]  IDX_ID3        = 4'h4;
  localparam logic [3:0]  IDX_P1         = 4'h5;
  localparam logic [3:0]  IDX_P4         = 4'h8;
  localparam logic [3:0]  CNT_MAX        = 4'hF;
  // parameter checks and reply
  localparam logic [3:0]  PROTO_TYPE     = 4'h1;
  localparam logic [3:0]  P3_UPPER       = 4'h0;
  localparam logic [3:0]  CID_NONE       = 4'h0;
  localparam logic [1:0]  RATE_106       = 2'h0;
  localparam logic [1:0]  RATE_212       = 2'h1;
  localparam logic [3:0]  FSIZE_256      = 4'h8;
  localparam logic [3:0]  FSIZE_128      = 4'h7;
  localparam logic [3:0]  FSIZE_96       = 4'h6;
  localparam logic [3:0]  FSIZE_64       = 4'h5;
  localparam logic [3:0]  BUF_LEN_CODE   = 4'h1;
  localparam logic [7:0]  ATTRIB_REPLY   = {BUF_LEN_CODE, CID_NONE};
  // crc_b: reflected ccitt, init all ones, residue over data plus crc
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL  = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE    = 16'hF0B8;
  // timing, fs in kHz, clock in MHz
  localparam int          FS_KHZ         = 848;
  localparam int          CLOCK_MHZ      = 125;
  localparam int          REPLY_DELAY_FS = 64;
  localparam int          SUB_LEAD_FS    = 80;
  localparam int          REPLY_DELAY_NS = (REPLY_DELAY_FS * 1000000 + FS_KHZ - 1) / FS_KHZ;
  localparam int          SUB_LEAD_NS    = (SUB_LEAD_FS * 1000000 + FS_KHZ - 1) / FS_KHZ;
  localparam int          REPLY_DELAY_CYC = (REPLY_DELAY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int          SUB_LEAD_CYC   = (SUB_LEAD_NS * CLOCK_MHZ + 999) / 1000;
  // register map
  localparam logic [7:0]  REG_PUPI       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_CTRL       = 8'h08;
  localparam logic [7:0]  REG_PARAMS     = 8'h0C;
  localparam logic [31:0] PUPI_RESET     = 32'h0000_0000;
  localparam int          CTRL_DESELECT  = 0;
  localparam int          CTRL_CLR_REJ   = 1;
  // main states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACTIVE = 2'b10
  } state_t;
endpackage

// ### logic/crc_b_check.sv
// Purpose: running crc_b over a received frame, residue compare
// Assumes: clear_i marks the start of a frame, bytes arrive lsb first
// Notes:   match_o is valid once the trailing crc bytes have been fed
`timescale 1ns/100ps
module crc_b_check
(
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       clear_i,
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_i,
  output logic            match_o
);
  logic [15:0] crc_ff;
  logic [15:0] base;
  logic [15:0] nxt_crc;

  // one byte through the reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ attrib_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  // clear restarts, a byte in the same cycle counts as the first
  assign base    = clear_i ? attrib_pkg::CRC_INIT : crc_ff;
  assign nxt_crc = byte_valid_i ? crc_step(base, byte_i) : base;
  assign match_o = (crc_ff == attrib_pkg::CRC_RESIDUE);

  // crc register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      crc_ff <= attrib_pkg::CRC_INIT;
    else
      crc_ff <= nxt_crc;
  end
endmodule

// ### logic/typeb_attrib_command_checker.sv
// Purpose: checks received type B attribute frames and enables commands
// Assumes: frame_start_i, byte_valid_i, frame_end_i from a local decoder
// Notes:   frame_end_i is a pulse after the last byte, never with a byte
//
// Overview of operation
// R1 - attribute frame is 0x1D, 4-byte id, four params, crc; valid one enables commands
// R2 - param1 bits 7-6 give reader-requested min_reply_delay codes
// R3 - param1 bits 5-4 give reader-requested min_subcarrier_lead codes
// R4 - reserved reply delay code reads as 00b; always 64/fs used
// R5 - reserved subcarrier lead code reads as 00b; always 80/fs used
// R6 - marker omission bits and bits 1-0 ignored; both markers always sent
// R7 - param2 rates 00b or 01b only, unsupported rate or size gives no reply
// R8 - differing rates in the two directions give no reply
// R9 - param2 bits 3-0 give reader frame size, 256/128/96/64 bytes
// R10 - param3 must be 0x01, upper zero, lower equals advertised type
// R11 - param4 upper ignored, lower must be zero, else no reply
// R12 - advertised protocol type is 0001b, reference for param3
// R13 - accepted frame answered with byte 0x10 then crc
// R14 - bad crc or foreign id drops the frame silently, no state change
`timescale 1ns/100ps
module typeb_attrib_command_checker
#(
  parameter int unsigned REPLY_DELAY_CYCLES = attrib_pkg::REPLY_DELAY_CYC,
  parameter int unsigned SUB_LEAD_CYCLES    = attrib_pkg::SUB_LEAD_CYC
)
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        frame_start_i,
  input  wire logic        byte_valid_i,
  input  wire logic [7:0]  byte_data_i,
  input  wire logic        frame_end_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic [31:0]      rdata_o,
  output logic             active_o,
  output logic             reply_start_o,
  output logic [7:0]       reply_byte_o,
  output logic [1:0]       reply_rate_o,
  output logic [3:0]       max_frame_code_o,
  output logic             send_sof_o,
  output logic             send_eof_o,
  output logic [15:0]      reply_delay_cycles_o,
  output logic [15:0]      subcarrier_lead_cycles_o
);
  attrib_pkg::state_t state_ff;
  attrib_pkg::state_t nxt_state;
  logic [3:0]  cnt_ff;
  logic [3:0]  cnt_base;
  logic [3:0]  nxt_cnt;
  logic [7:0]  cmd_ff;
  logic [31:0] id_ff;
  logic [31:0] par_ff;
  logic [31:0] pupi_ff;
  logic        rej_ff;
  logic        reply_ff;
  logic [7:0]  reply_byte_ff;
  logic [1:0]  rate_ff;
  logic [3:0]  fsize_ff;
  logic [31:0] rdata_ff;
  logic        crc_ok;
  logic [7:0]  p1;
  logic [7:0]  p2;
  logic [7:0]  p3;
  logic [7:0]  p4;
  logic        len_ok;
  logic        cmd_ok;
  logic        id_ok;
  logic        rate_ok;
  logic        fsize_ok;
  logic        p3_ok;
  logic        p4_ok;
  logic        params_ok;
  logic        check;
  logic        accept;
  logic        reject;
  logic        wr_ctrl;
  logic        deselect;
  logic        clr_rej;
  logic [1:0]  p1_reply_code;
  logic [1:0]  p1_lead_code;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  // supported reader frame size codes
  function automatic logic fsize_supported(input logic [3:0] code);
    return (code == attrib_pkg::FSIZE_256) || (code == attrib_pkg::FSIZE_128) ||
           (code == attrib_pkg::FSIZE_96) || (code == attrib_pkg::FSIZE_64);
  endfunction

  // supported single-direction rate codes
  function automatic logic rate_supported(input logic [1:0] code);
    return (code == attrib_pkg::RATE_106) || (code == attrib_pkg::RATE_212);
  endfunction

  // running crc over every byte of the frame
  crc_b_check u_crc
  (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .clear_i      (frame_start_i),
    .byte_valid_i (byte_valid_i),
    .byte_i       (byte_data_i),
    .match_o      (crc_ok)
  );

  // byte position, saturating so long frames stay too long
  assign cnt_base = frame_start_i ? 4'h0 : cnt_ff;
  assign nxt_cnt  = (byte_valid_i && cnt_base != attrib_pkg::CNT_MAX) ? cnt_base + 4'h1
                                                                      : cnt_base;

  // frame byte position and field capture
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= 4'h0;
      cmd_ff <= 8'h00;
      id_ff  <= 32'h0000_0000;
      par_ff <= 32'h0000_0000;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      if (byte_valid_i && cnt_base == attrib_pkg::IDX_CMD)
        cmd_ff <= byte_data_i;
      if (byte_valid_i && cnt_base >= attrib_pkg::IDX_ID0 && cnt_base <= attrib_pkg::IDX_ID3)
        id_ff <= {id_ff[23:0], byte_data_i};
      if (byte_valid_i && cnt_base >= attrib_pkg::IDX_P1 && cnt_base <= attrib_pkg::IDX_P4)
        par_ff <= {par_ff[23:0], byte_data_i};
    end
  end

  // parameter bytes, first received in the top byte
  assign p1 = par_ff[31:24];
  assign p2 = par_ff[23:16];
  assign p3 = par_ff[15:8];
  assign p4 = par_ff[7:0];

  // R2 requested codes
  // R3 kept only for status
  assign p1_reply_code = p1[7:6];
  assign p1_lead_code  = p1[5:4];

  // R1 frame shape
  assign len_ok   = (cnt_ff == attrib_pkg::FRAME_LEN);
  assign cmd_ok   = (cmd_ff == attrib_pkg::CMD_ATTRIB);
  // R14 identifier match
  assign id_ok    = (id_ff == pupi_ff);
  // R7 R8 rate checks
  assign rate_ok  = rate_supported(p2[7:6]) && rate_supported(p2[5:4]) && (p2[7:6] == p2[5:4]);
  // R9 frame size codes
  assign fsize_ok = fsize_supported(p2[3:0]);
  // R10 R12 param3 against advertised type
  assign p3_ok    = (p3 == {attrib_pkg::P3_UPPER, attrib_pkg::PROTO_TYPE});
  // R11 no card identifier
  assign p4_ok    = (p4[3:0] == attrib_pkg::CID_NONE);
  // R6 param1 never rejects
  assign params_ok = rate_ok && fsize_ok && p3_ok && p4_ok;

  // decision at frame end, only while waiting for selection
  assign check  = frame_end_i && (state_ff == attrib_pkg::ST_IDLE) && len_ok && cmd_ok;
  assign accept = check && crc_ok && id_ok && params_ok;
  assign reject = check && !accept;

  // register bus decode
  assign wr_ctrl  = we_i && (addr_i == attrib_pkg::REG_CTRL);
  assign deselect = wr_ctrl && wdata_i[attrib_pkg::CTRL_DESELECT];
  assign clr_rej  = wr_ctrl && wdata_i[attrib_pkg::CTRL_CLR_REJ];

  // R1 R14 idle to active only on acceptance, a deselect write returns to idle
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      attrib_pkg::ST_IDLE:
        if (accept)
          nxt_state = attrib_pkg::ST_ACTIVE;
      attrib_pkg::ST_ACTIVE:
        if (deselect)
          nxt_state = attrib_pkg::ST_IDLE;
      default:
        nxt_state = attrib_pkg::ST_IDLE;
    endcase
  end

  // state, reply trigger and negotiated settings
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff      <= attrib_pkg::ST_IDLE;
      reply_ff      <= 1'b0;
      reply_byte_ff <= attrib_pkg::ATTRIB_REPLY;
      rate_ff       <= attrib_pkg::RATE_106;
      fsize_ff      <= attrib_pkg::FSIZE_256;
    end
    else
    begin
      state_ff <= nxt_state;
      // R13 reply code on acceptance
      reply_ff      <= accept;
      reply_byte_ff <= attrib_pkg::ATTRIB_REPLY;
      if (accept)
      begin
        rate_ff  <= p2[7:6];
        fsize_ff <= p2[3:0];
      end
    end
  end

  // software registers, reject flag set wins over clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pupi_ff <= attrib_pkg::PUPI_RESET;
      rej_ff  <= 1'b0;
    end
    else
    begin
      if (we_i && addr_i == attrib_pkg::REG_PUPI)
        pupi_ff <= wdata_i;
      rej_ff <= reject | (rej_ff & ~clr_rej);
    end
  end

  // read selection, unmapped reads zero
  assign status_word = {16'h0000, p1_lead_code, p1_reply_code, fsize_ff,
                        2'h0, rate_ff, 2'h0, rej_ff, (state_ff == attrib_pkg::ST_ACTIVE)};
  assign rd_mux = (addr_i == attrib_pkg::REG_PUPI)   ? pupi_ff :
                  (addr_i == attrib_pkg::REG_STATUS) ? status_word :
                  (addr_i == attrib_pkg::REG_PARAMS) ? par_ff : 32'h0000_0000;

  // read data only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= re_i ? rd_mux : 32'h0000_0000;
  end

  assign rdata_o          = rdata_ff;
  assign active_o         = (state_ff == attrib_pkg::ST_ACTIVE);
  assign reply_start_o    = reply_ff;
  assign reply_byte_o     = reply_byte_ff;
  assign reply_rate_o     = rate_ff;
  assign max_frame_code_o = fsize_ff;
  // R6 markers always present
  assign send_sof_o = 1'b1;
  assign send_eof_o = 1'b1;
  // R4 R5 fixed minimum delays whatever was requested
  assign reply_delay_cycles_o     = 16'(REPLY_DELAY_CYCLES);
  assign subcarrier_lead_cycles_o = 16'(SUB_LEAD_CYCLES);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  accept_activates_a: assert property (accept |=> active_o && reply_start_o) // R1
    else $error("accepted frame did not enable commands");
  reply_code_a: assert property (reply_start_o |-> reply_byte_o == 8'h10 && !$past(active_o)) // R13
    else $error("reply code wrong or reply while active");
  crc_drop_a: assert property (frame_end_i && !crc_ok && !deselect |=> // R14
                              !reply_start_o && $stable(active_o))
    else $error("bad crc frame answered");
  id_drop_a: assert property (frame_end_i && (id_ff != pupi_ff) |=> !reply_start_o) // R14
    else $error("foreign id answered");
  rate_mismatch_a: assert property (frame_end_i && p2[7:6] != p2[5:4] |=> !reply_start_o) // R8
    else $error("mismatched rates answered");
  rate_size_a: assert property (frame_end_i && (p2[7] || p2[5] || // R7
                                !fsize_supported(p2[3:0])) |=> !reply_start_o)
    else $error("unsupported rate or size answered");
  param3_a: assert property (frame_end_i && p3 != 8'h01 |=> !reply_start_o) // R10
    else $error("bad param3 answered");
  cid_a: assert property (frame_end_i && p4[3:0] != 4'h0 |=> !reply_start_o) // R11
    else $error("card identifier request answered");
  rate_latch_a: assert property (accept |=> reply_rate_o == $past(p2[7:6]) && // R9
                                 max_frame_code_o == $past(p2[3:0]))
    else $error("negotiated settings not latched");
  markers_a: assert property (send_sof_o && send_eof_o && // R6
                              reply_delay_cycles_o == 16'(REPLY_DELAY_CYCLES) &&
                              subcarrier_lead_cycles_o == 16'(SUB_LEAD_CYCLES))
    else $error("markers or fixed delays changed");

  accept_c: cover property (accept ##1 active_o);
  crc_reject_c: cover property (frame_end_i && len_ok && cmd_ok && !crc_ok);
  param_reject_c: cover property (reject ##1 rej_ff);
  deselect_c: cover property (active_o ##1 deselect ##1 !active_o);
endmodule

// ### testbench/reader_model.sv
// Purpose: reader side model that drives attribute frames into the tag
// Assumes: one clock shared with the tag, byte level link, no gaps required
// Notes:   data line shows 0xA5 before the first byte, then the inverse of the last byte whenever no byte is valid
`timescale 1ns/100ps
module reader_model
(
  input  wire logic  clock_i,
  output logic       frame_start_o,
  output logic       byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic       frame_end_o
);
  // idle link at time zero
  initial
  begin
    frame_start_o = 1'b0;
    byte_valid_o  = 1'b0;
    byte_data_o   = 8'hA5;
    frame_end_o   = 1'b0;
  end

  // one byte of crc_b, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ attrib_pkg::CRC_POLY_REFL) : (r >> 1);
    return r;
  endfunction

  // command, identifier, params, crc low first
  task automatic send_frame(input logic [71:0] body, input int nbytes, input logic bad_crc,
                            input int gap);
    logic [7:0]  b [11];
    logic [15:0] c;
    c = attrib_pkg::CRC_INIT;
    for (int i = 0; i < 9; i++)
    begin
      b[i] = body[71-8*i -: 8];
      c    = crc_step(c, b[i]);
    end
    c     = ~c;
    b[9]  = c[7:0] ^ {7'h00, bad_crc};
    b[10] = c[15:8];
    for (int i = 0; i < nbytes; i++)
    begin
      if (i > 0 && gap > 0)
      begin
        @(posedge clock_i);
        frame_start_o <= 1'b0;
        byte_valid_o  <= 1'b0;
        byte_data_o   <= ~b[i-1];
        repeat (gap - 1) @(posedge clock_i);
      end
      @(posedge clock_i);
      frame_start_o <= (i == 0);
      byte_valid_o  <= 1'b1;
      byte_data_o   <= b[i];
    end
    @(posedge clock_i);
    frame_start_o <= 1'b0;
    byte_valid_o  <= 1'b0;
    byte_data_o   <= ~b[nbytes-1];
    frame_end_o   <= 1'b1;
    @(posedge clock_i);
    frame_end_o   <= 1'b0;
  endtask
endmodule

// ### testbench/typeb_attrib_command_checker_test.sv
// Purpose: self-checking bench for the attribute command checker
// Assumes: shortened delay parameters, fixed seed for random frames
// Notes:   every accepted frame is followed by a deselect write
`timescale 1ns/100ps
module typeb_attrib_command_checker_test;
  logic        clock_i;
  logic        nrst_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        we_i;
  logic        re_i;
  wire         frame_start;
  wire         byte_valid;
  wire  [7:0]  byte_data;
  wire         frame_end;
  logic [31:0] rdata_o;
  logic        active_o;
  logic        reply_start_o;
  logic [7:0]  reply_byte_o;
  logic [1:0]  reply_rate_o;
  logic [3:0]  max_frame_code_o;
  logic        send_sof_o;
  logic        send_eof_o;
  logic [15:0] reply_delay_cycles_o;
  logic [15:0] subcarrier_lead_cycles_o;
  int          n_errors;
  int          num_checks;
  int          seed;
  logic [31:0] pupi;
  logic [31:0] d;
  logic [31:0] r;
  logic [31:0] cp [8];

  reader_model reader_u (.clock_i(clock_i), .frame_start_o(frame_start),
    .byte_valid_o(byte_valid), .byte_data_o(byte_data), .frame_end_o(frame_end));

  typeb_attrib_command_checker #(.REPLY_DELAY_CYCLES(16), .SUB_LEAD_CYCLES(20)) dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .frame_start_i(frame_start),
    .byte_valid_i(byte_valid), .byte_data_i(byte_data), .frame_end_i(frame_end),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .active_o(active_o), .reply_start_o(reply_start_o), .reply_byte_o(reply_byte_o),
    .reply_rate_o(reply_rate_o), .max_frame_code_o(max_frame_code_o),
    .send_sof_o(send_sof_o), .send_eof_o(send_eof_o),
    .reply_delay_cycles_o(reply_delay_cycles_o),
    .subcarrier_lead_cycles_o(subcarrier_lead_cycles_o));

  // free running clock
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic close_out;
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    we_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clock_i);
    we_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    re_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    re_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  // acceptance of a well formed frame from its params
  function automatic logic want(input logic [31:0] p);
    return (p[23:22] == p[21:20]) && (p[23:22] <= 2'h1) && (p[19:16] >= 4'h5) &&
           (p[19:16] <= 4'h8) && (p[15:8] == 8'h01) && (p[3:0] == 4'h0);
  endfunction

  task automatic frame_case(input logic [7:0] cmd, input logic [31:0] id, input logic [31:0] p,
                            input int nb, input logic bad, input logic ok, input int gap);
    logic [31:0] v;
    reader_u.send_frame({cmd, id, p}, nb, bad, gap);
    #1;
    chk(reply_start_o, ok);
    chk(active_o, ok);
    chk(reply_byte_o, 8'h10);
    chk({send_sof_o, send_eof_o}, 2'b11);
    chk(reply_delay_cycles_o, 16'h0010);
    chk(subcarrier_lead_cycles_o, 16'h0014);
    @(posedge clock_i);
    #1 chk(reply_start_o, 1'b0);
    if (ok)
    begin
      chk(reply_rate_o, p[23:22]);
      chk(max_frame_code_o, p[19:16]);
      reg_rd(attrib_pkg::REG_STATUS, v);
      chk(v & 32'h0000_FF33, {16'h0, p[29:28], p[31:30], p[19:16], 2'b00, p[23:22], 4'h1});
      reg_rd(attrib_pkg::REG_PARAMS, v);
      chk(v, p);
      @(posedge clock_i);
      #1 chk(rdata_o, 32'h0);
      reader_u.send_frame({cmd, id, p}, nb, bad, 0);
      #1 chk(reply_start_o, 1'b0);
      reg_wr(attrib_pkg::REG_CTRL, 32'h1);
      @(posedge clock_i);
      #1 chk(active_o, 1'b0);
    end
    else
    begin
      // reject flag only for a well formed attribute frame, then cleared
      reg_rd(attrib_pkg::REG_STATUS, v);
      chk(v[1:0], {cmd == 8'h1D && nb == 11, 1'b0});
      reg_wr(attrib_pkg::REG_CTRL, 32'h2);
      reg_rd(attrib_pkg::REG_STATUS, v);
      chk(v[1:0], 2'b00);
    end
  endtask

  // watchdog against a hung run
  initial
  begin
    repeat (40000) @(posedge clock_i);
    n_errors++;
    close_out();
  end

  // main sequence
  initial
  begin
    n_errors   = 0;
    num_checks = 0;
    seed       = 32'h899B;
    nrst_i     = 1'b0;
    addr_i     = 8'h00;
    wdata_i    = 32'h0;
    we_i       = 1'b0;
    re_i       = 1'b0;
    cp = '{32'h0018_0100, 32'h0009_0100, 32'h0004_0100, 32'h0008_1100,
           32'h0008_0200, 32'h0008_0101, 32'h00AA_0100, 32'h3C56_01A0};
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    #1 chk({active_o, reply_start_o, reply_rate_o, max_frame_code_o}, 8'h08);
    reg_rd(attrib_pkg::REG_PUPI, d);
    chk(d, 32'h0);
    reg_wr(8'h40, 32'hFFFF_FFFF);
    reg_rd(8'h40, d);
    chk(d, 32'h0);
    pupi = $random(seed);
    reg_wr(attrib_pkg::REG_PUPI, pupi);
    reg_rd(attrib_pkg::REG_PUPI, d);
    chk(d, pupi);
    frame_case(8'h1D, pupi, 32'h0008_0100, 11, 1'b0, 1'b1, 0);
    frame_case(8'h1D, pupi, 32'hFF55_01F0, 11, 1'b0, 1'b1, 1);
    frame_case(8'h1D, pupi, 32'h0008_0100, 11, 1'b1, 1'b0, 0);
    frame_case(8'h1D, pupi ^ 32'h1, 32'h0008_0100, 11, 1'b0, 1'b0, 0);
    frame_case(8'h50, pupi, 32'h0008_0100, 11, 1'b0, 1'b0, 0);
    frame_case(8'h1D, pupi, 32'h0008_0100, 10, 1'b0, 1'b0, 0);
    for (int i = 0; i < 8; i++)
      frame_case(8'h1D, pupi, cp[i], 11, 1'b0, want(cp[i]), 0);
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      d[31:24] = 8'($random(seed));
      d[23:22] = r[2] ? r[1:0] : {1'b0, r[0]};
      d[21:20] = r[3] ? d[23:22] : r[5:4];
      d[19:16] = r[6] ? 4'h5 + {2'b00, r[8:7]} : r[11:8];
      d[15:8]  = r[12] ? 8'h01 : r[20:13];
      d[7:0]   = {r[24:21], r[25] ? 4'h0 : r[29:26]};
      frame_case(8'h1D, pupi, d, 11, 1'b0, want(d), int'(r[31:30]));
    end
    close_out();
  end
endmodule
